// *** rtl/ser_top.sv ***
// Status and event reporting logic: event latch, mask and three
// sixteen-bit condition/event/enable status registers.
// Assumes a command parser on the same clock that issues decoded
// one-cycle commands; condition inputs arrive asynchronously.
//
// Notes on behaviour
// - Set bit 0 after opc, pending work done
// - Set bit 2 on unexpected read or abandoned reply
// - Device fault sets bit 3, logs -300..-399
// - Execution fault sets bit 4, logs -200..-299
// - Bad command sets bit 5, logs -100..-199
// - Power up sets bit 7
// - Mask register writable and readable by command
// - Event latch holds occurrences, read by query
// - Operation register has condition and event parts
// - Operation bit 0 high during calibration
// - Bit 15 of status words reads zero
// - Questionable bit 2 on low battery
// - Questionable bit 4 on bad temperature
// - Questionable bit 9 on limit violation
// - Questionable bit 10 on unaligned measurement
// - Frequency bit 8 while external reference used
// - Summary bit 5 from enabled event bits
// - Summary bit 3 from enabled questionable events
// - Summary bit 7 from enabled operation events
`timescale 1ns/1ps
`include "ser_consts.svh"

module ser_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Decoded command from the parser
    input wire logic cmd_valid,
    input wire ser_pkg::ser_op_e cmd_op,
    input wire logic [15:0] cmd_data,
    // Query response
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    // Parser progress and message events
    input wire logic opc_cmd,
    input wire logic cmds_pending,
    input wire logic host_read_req,
    input wire logic new_cmd,
    input wire logic out_pending,
    // Error events with detail index
    input wire logic dev_err,
    input wire logic exec_err,
    input wire logic cmd_err,
    input wire logic [7:0] err_detail,
    // Error log output
    output logic err_log_valid,
    output logic [15:0] err_log_code,
    // Instrument conditions, asynchronous
    input wire logic calibration_in_progress,
    input wire logic battery_low,
    input wire logic temp_abnormal,
    input wire logic limit_violated,
    input wire logic unaligned_label,
    input wire logic ext_ref_used,
    // Summary byte
    output logic [7:0] status_summary,
    output logic event_summary_flag
);
    import ser_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Next event word: rising edges set, read clears, set wins
    function automatic ser_word_t rise_latch(input ser_word_t evt, input ser_word_t cond,
                                             input ser_word_t prev, input logic clr,
                                             input ser_word_t valid);
        ser_word_t held;
        held = clr ? 16'h0000 : evt;
        rise_latch = (held | (cond & ~prev)) & valid;
    endfunction

    // Error code from class base and detail, detail clamped in span
    function automatic logic [15:0] err_code(input logic [15:0] base, input logic [7:0] det);
        logic [7:0] d;
        d = (det > `SER_CODE_SPAN) ? `SER_CODE_SPAN : det;
        err_code = base - {8'h00, d};
    endfunction

    // ------------------------------------------------------------
    // Condition synchroniser
    // ------------------------------------------------------------

    // Raw condition inputs gathered into one vector
    wire logic [5:0] cond_raw;
    assign cond_raw = {ext_ref_used, unaligned_label, limit_violated,
                       temp_abnormal, battery_low, calibration_in_progress};

    logic [5:0] sync1_q; // First stage, read only by second stage
    logic [5:0] sync2_q; // Stable conditions

    // Two flops per asynchronous level before any logic
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= cond_raw;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Condition parts
    // ------------------------------------------------------------

    // Condition words placed at their documented bit positions
    wire ser_word_t oper_cond;
    wire ser_word_t ques_cond;
    wire ser_word_t freq_cond;
    assign oper_cond = {15'h0000, sync2_q[0]};
    assign ques_cond = {5'h00, sync2_q[4], sync2_q[3], 4'h0, sync2_q[2], 1'b0,
                        sync2_q[1], 2'h0};
    assign freq_cond = {7'h00, sync2_q[5], 8'h00};

    // Previous conditions for edge detection
    ser_word_t oper_prev_q;
    ser_word_t ques_prev_q;
    ser_word_t freq_prev_q;

    // Sampled each cycle so every rise is seen once
    always_ff @(posedge clk) begin
        if (srst) begin
            oper_prev_q <= 16'h0000;
            ques_prev_q <= 16'h0000;
            freq_prev_q <= 16'h0000;
        end else begin
            oper_prev_q <= oper_cond;
            ques_prev_q <= ques_cond;
            freq_prev_q <= freq_cond;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------

    // One strobe per command code that changes state
    wire logic op_evt_rd;
    wire logic op_mask_wr;
    wire logic op_clear;
    wire logic op_oper_evt;
    wire logic op_ques_evt;
    wire logic op_freq_evt;
    wire logic op_oper_ena_wr;
    wire logic op_ques_ena_wr;
    wire logic op_freq_ena_wr;
    assign op_evt_rd = cmd_valid && (cmd_op == SER_OP_EVT_RD);
    assign op_mask_wr = cmd_valid && (cmd_op == SER_OP_MASK_WR);
    assign op_clear = cmd_valid && (cmd_op == SER_OP_CLEAR);
    assign op_oper_evt = cmd_valid && (cmd_op == SER_OP_OPER_EVT);
    assign op_ques_evt = cmd_valid && (cmd_op == SER_OP_QUES_EVT);
    assign op_freq_evt = cmd_valid && (cmd_op == SER_OP_FREQ_EVT);
    assign op_oper_ena_wr = cmd_valid && (cmd_op == SER_OP_OPER_ENA_WR);
    assign op_ques_ena_wr = cmd_valid && (cmd_op == SER_OP_QUES_ENA_WR);
    assign op_freq_ena_wr = cmd_valid && (cmd_op == SER_OP_FREQ_ENA_WR);

    // ------------------------------------------------------------
    // Operation complete tracking
    // ------------------------------------------------------------

    logic opc_armed_q; // Waiting for earlier commands to finish

    // Armed by the request, disarmed once it fires or on clear
    wire logic opc_fire;
    assign opc_fire = (opc_armed_q || opc_cmd) && !cmds_pending;

    always_ff @(posedge clk) begin
        if (srst) begin
            opc_armed_q <= 1'b0;
        end else if (opc_fire) begin
            opc_armed_q <= 1'b0;
        end else if (opc_cmd) begin
            opc_armed_q <= 1'b1;
        end else if (op_clear) begin
            opc_armed_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Standard event latch and mask
    // ------------------------------------------------------------

    // Query protocol violation
    wire logic qry_err;
    assign qry_err = (host_read_req && !out_pending) || (new_cmd && out_pending);

    // Bits raised this cycle
    wire logic [7:0] ev_set;
    assign ev_set = {1'b0, 1'b0, cmd_err, exec_err, dev_err, qry_err, 1'b0, opc_fire};

    logic [7:0] ev_latch_q; // Standard event latch
    logic [7:0] ev_latch_d;
    logic [7:0] ev_mask_q; // Standard event mask
    logic [7:0] ev_mask_d;

    // Read or clear empties it; a new event in that cycle survives
    assign ev_latch_d = (((op_evt_rd || op_clear) ? 8'h00 : ev_latch_q) | ev_set)
                        & `SER_EV_VALID;
    assign ev_mask_d = op_mask_wr ? cmd_data[7:0] : ev_mask_q;

    // Reset stands for switching on, so the power bit starts set
    always_ff @(posedge clk) begin
        if (srst) begin
            ev_latch_q <= `SER_EV_RESET;
            ev_mask_q <= `SER_MASK_RESET;
        end else begin
            ev_latch_q <= ev_latch_d;
            ev_mask_q <= ev_mask_d;
        end
    end

    // ------------------------------------------------------------
    // Status event and enable parts
    // ------------------------------------------------------------

    ser_word_t oper_evt_q;
    ser_word_t ques_evt_q;
    ser_word_t freq_evt_q;
    ser_word_t oper_ena_q;
    ser_word_t ques_ena_q;
    ser_word_t freq_ena_q;

    // Next event parts; clear command empties all of them
    wire ser_word_t oper_evt_d;
    wire ser_word_t ques_evt_d;
    wire ser_word_t freq_evt_d;
    assign oper_evt_d = rise_latch(oper_evt_q, oper_cond, oper_prev_q,
                                   op_oper_evt || op_clear, `SER_OP_VALID);
    assign ques_evt_d = rise_latch(ques_evt_q, ques_cond, ques_prev_q,
                                   op_ques_evt || op_clear, `SER_QU_VALID);
    assign freq_evt_d = rise_latch(freq_evt_q, freq_cond, freq_prev_q,
                                   op_freq_evt || op_clear, `SER_FQ_VALID);

    // Enables keep only meaningful bits so bit 15 never sets
    wire ser_word_t oper_ena_d;
    wire ser_word_t ques_ena_d;
    wire ser_word_t freq_ena_d;
    assign oper_ena_d = op_oper_ena_wr ? (cmd_data & `SER_OP_VALID) : oper_ena_q;
    assign ques_ena_d = op_ques_ena_wr ? (cmd_data & `SER_QU_VALID) : ques_ena_q;
    assign freq_ena_d = op_freq_ena_wr ? (cmd_data & `SER_FQ_VALID) : freq_ena_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            oper_evt_q <= 16'h0000;
            ques_evt_q <= 16'h0000;
            freq_evt_q <= 16'h0000;
            oper_ena_q <= `SER_ENA_RESET;
            ques_ena_q <= `SER_ENA_RESET;
            freq_ena_q <= `SER_ENA_RESET;
        end else begin
            oper_evt_q <= oper_evt_d;
            ques_evt_q <= ques_evt_d;
            freq_evt_q <= freq_evt_d;
            oper_ena_q <= oper_ena_d;
            ques_ena_q <= ques_ena_d;
            freq_ena_q <= freq_ena_d;
        end
    end

    // ------------------------------------------------------------
    // Summary byte
    // ------------------------------------------------------------

    // Summaries are registered from the stored parts, so two cycles behind an event
    wire logic sum_evt;
    wire logic sum_ques;
    wire logic sum_oper;
    assign sum_evt = |(ev_latch_q & ev_mask_q);
    assign sum_ques = |(ques_evt_q & ques_ena_q);
    assign sum_oper = |(oper_evt_q & oper_ena_q);

    logic [7:0] summary_q;
    wire logic [7:0] summary_d;
    assign summary_d = {sum_oper, 1'b0, sum_evt, 1'b0, sum_ques, 3'h0};

    always_ff @(posedge clk) begin
        if (srst) begin
            summary_q <= 8'h00;
        end else begin
            summary_q <= summary_d;
        end
    end

    assign status_summary = summary_q;
    assign event_summary_flag = summary_q[`SER_SUM_EVT_BIT];

    // ------------------------------------------------------------
    // Query response
    // ------------------------------------------------------------

    // Read mux; event reads return the value before clearing
    logic [15:0] rsp_sel;
    logic rsp_hit;
    always_comb begin
        rsp_sel = 16'h0000;
        rsp_hit = 1'b1;
        case (cmd_op)
            SER_OP_EVT_RD: rsp_sel = {8'h00, ev_latch_q};
            SER_OP_MASK_RD: rsp_sel = {8'h00, ev_mask_q};
            SER_OP_OPER_COND: rsp_sel = oper_cond;
            SER_OP_OPER_EVT: rsp_sel = oper_evt_q;
            SER_OP_OPER_ENA_RD: rsp_sel = oper_ena_q;
            SER_OP_QUES_COND: rsp_sel = ques_cond;
            SER_OP_QUES_EVT: rsp_sel = ques_evt_q;
            SER_OP_QUES_ENA_RD: rsp_sel = ques_ena_q;
            SER_OP_FREQ_COND: rsp_sel = freq_cond;
            SER_OP_FREQ_EVT: rsp_sel = freq_evt_q;
            SER_OP_FREQ_ENA_RD: rsp_sel = freq_ena_q;
            SER_OP_SUM_RD: rsp_sel = {8'h00, summary_q};
            default: rsp_hit = 1'b0; // Writes and clear give no reply
        endcase
    end

    logic rsp_valid_q;
    logic [15:0] rsp_data_q;

    // Reply one cycle after the command, bit 15 forced low
    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
        end else begin
            rsp_valid_q <= cmd_valid && rsp_hit;
            rsp_data_q <= {1'b0, rsp_sel[14:0]};
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;

    // ------------------------------------------------------------
    // Error log
    // ------------------------------------------------------------

    // One entry per cycle; command errors win, then execution, then
    // device. Simultaneous lower classes still set their bits but
    // are not logged, a trade against a queue in this block.
    wire logic any_err;
    wire logic [15:0] code_sel;
    assign any_err = cmd_err || exec_err || dev_err;
    assign code_sel = cmd_err ? err_code(`SER_CODE_CMD_BASE, err_detail) :
                      exec_err ? err_code(`SER_CODE_EXE_BASE, err_detail) :
                      err_code(`SER_CODE_DEV_BASE, err_detail);

    logic err_valid_q;
    logic [15:0] err_code_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            err_valid_q <= 1'b0;
            err_code_q <= 16'h0000;
        end else begin
            err_valid_q <= any_err;
            if (any_err) begin
                err_code_q <= code_sel;
            end
        end
    end

    assign err_log_valid = err_valid_q;
    assign err_log_code = err_code_q;

endmodule

// *** rtl/ser_consts.svh ***
// Constants for the status and event reporting block.
// Assumes inclusion by bare name from the top module.
`ifndef SER_CONSTS_SVH
`define SER_CONSTS_SVH

// ----------------------------------------------------------------
// Standard event latch bit positions
// ----------------------------------------------------------------
`define SER_EV_OPC_BIT 0
`define SER_EV_QRY_BIT 2
`define SER_EV_DEV_BIT 3
`define SER_EV_EXE_BIT 4
`define SER_EV_CMD_BIT 5
`define SER_EV_PON_BIT 7
`define SER_EV_OPC 0
`define SER_EV_VALID 8'hbd
`define SER_EV_RESET 8'h80
`define SER_MASK_RESET 8'h00

// ----------------------------------------------------------------
// Sixteen-bit status register bit positions and valid masks
// ----------------------------------------------------------------
`define SER_OP_CAL_BIT 0
`define SER_QU_BATT_BIT 2
`define SER_QU_TEMP_BIT 4
`define SER_QU_LIM_BIT 9
`define SER_QU_UNAL_BIT 10
`define SER_FQ_EXT_BIT 8
`define SER_OP_VALID 16'h0001
`define SER_QU_VALID 16'h0614
`define SER_FQ_VALID 16'h0100
`define SER_ENA_RESET 16'h0000

// ----------------------------------------------------------------
// Summary byte bit positions
// ----------------------------------------------------------------
`define SER_SUM_QUES_BIT 3
`define SER_SUM_EVT_BIT 5
`define SER_SUM_OPER_BIT 7

// ----------------------------------------------------------------
// Error code bases and span of each class
// ----------------------------------------------------------------
`define SER_CODE_CMD_BASE 16'shff9c
`define SER_CODE_EXE_BASE 16'shff38
`define SER_CODE_DEV_BASE 16'shfed4
`define SER_CODE_SPAN 8'h63

`endif

// *** rtl/ser_pkg.sv ***
// Types shared by the status and event reporting block.
// Assumes the constants header is on the include path.
package ser_pkg;
    // ------------------------------------------------------------
    // Command codes from the remote command parser
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        SER_OP_NOP = 5'h00,
        SER_OP_EVT_RD = 5'h01,
        SER_OP_MASK_WR = 5'h02,
        SER_OP_MASK_RD = 5'h03,
        SER_OP_CLEAR = 5'h04,
        SER_OP_OPER_COND = 5'h05,
        SER_OP_OPER_EVT = 5'h06,
        SER_OP_OPER_ENA_WR = 5'h07,
        SER_OP_OPER_ENA_RD = 5'h08,
        SER_OP_QUES_COND = 5'h09,
        SER_OP_QUES_EVT = 5'h0a,
        SER_OP_QUES_ENA_WR = 5'h0b,
        SER_OP_QUES_ENA_RD = 5'h0c,
        SER_OP_FREQ_COND = 5'h0d,
        SER_OP_FREQ_EVT = 5'h0e,
        SER_OP_FREQ_ENA_WR = 5'h0f,
        SER_OP_FREQ_ENA_RD = 5'h10,
        SER_OP_SUM_RD = 5'h11
    } ser_op_e;

    // Sixteen-bit status word
    typedef logic [15:0] ser_word_t;
endpackage

// *** dv/ser_top_chk.sv ***
// Assertion checker for the status reporting block.
// Assumes it is bound to ser_top and sees only its ports.
`timescale 1ns/1ps
module ser_top_chk
    import ser_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Command and reply
    input wire logic cmd_valid,
    input wire ser_pkg::ser_op_e cmd_op,
    input wire logic [15:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    // Faults and error log
    input wire logic dev_err,
    input wire logic exec_err,
    input wire logic cmd_err,
    input wire logic [7:0] err_detail,
    input wire logic err_log_valid,
    input wire logic [15:0] err_log_code,
    // Summary
    input wire logic [7:0] status_summary,
    input wire logic event_summary_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Clamped detail index, lined up with the logged code
    logic [7:0] det_q;
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        det_q <= (err_detail > 8'h63) ? 8'h63 : err_detail;
    end
    // ----------------------------------------------------------------
    // Sequences and properties
    // ----------------------------------------------------------------
    sequence s_rd;
        cmd_valid && cmd_op inside {SER_OP_EVT_RD, SER_OP_MASK_RD, SER_OP_OPER_COND, SER_OP_OPER_EVT,
            SER_OP_OPER_ENA_RD, SER_OP_QUES_COND, SER_OP_QUES_EVT, SER_OP_QUES_ENA_RD, SER_OP_FREQ_COND,
            SER_OP_FREQ_EVT, SER_OP_FREQ_ENA_RD, SER_OP_SUM_RD};
    endsequence
    sequence s_reply;
        rsp_valid && rsp_data[15] == 1'b0;
    endsequence
    sequence s_wr_rd;
        (cmd_valid && cmd_op == SER_OP_MASK_WR) ##1 (cmd_valid && cmd_op == SER_OP_MASK_RD);
    endsequence
    property p_rd_reply; s_rd |=> s_reply; endproperty
    property p_wr_silent;
        cmd_valid && cmd_op inside {SER_OP_NOP, SER_OP_MASK_WR, SER_OP_CLEAR, SER_OP_OPER_ENA_WR,
            SER_OP_QUES_ENA_WR, SER_OP_FREQ_ENA_WR} |=> !rsp_valid;
    endproperty
    property p_mask_back; s_wr_rd |=> rsp_valid && rsp_data == {8'h00, $past(cmd_data[7:0], 2)}; endproperty
    property p_flag; event_summary_flag == status_summary[5]; endproperty
    property p_sum_unused; (status_summary & 8'h57) == 8'h00; endproperty
    property p_cmd_code; cmd_err |=> err_log_valid && err_log_code == 16'hff9c - {8'h00, det_q}; endproperty
    property p_exe_code;
        exec_err && !cmd_err |=> err_log_valid && err_log_code == 16'hff38 - {8'h00, det_q};
    endproperty
    property p_dev_code;
        dev_err && !exec_err && !cmd_err |=> err_log_valid && err_log_code == 16'hfed4 - {8'h00, det_q};
    endproperty
    property p_no_log; !(dev_err || exec_err || cmd_err) |=> !err_log_valid; endproperty
    a_rd_reply: assert property (p_rd_reply) else $error("read gave no clean reply");
    a_wr_silent: assert property (p_wr_silent) else $error("write gave a reply");
    a_mask_back: assert property (p_mask_back) else $error("mask readback wrong");
    a_flag: assert property (p_flag) else $error("summary flag differs");
    a_sum_unused: assert property (p_sum_unused) else $error("unused summary bit set");
    a_cmd_code: assert property (p_cmd_code) else $error("command error code wrong");
    a_exe_code: assert property (p_exe_code) else $error("execution error code wrong");
    a_dev_code: assert property (p_dev_code) else $error("device error code wrong");
    a_no_log: assert property (p_no_log) else $error("log without fault");
endmodule

bind ser_top ser_top_chk ser_top_chk_inst (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dev_err(dev_err), .exec_err(exec_err),
    .cmd_err(cmd_err), .err_detail(err_detail), .err_log_valid(err_log_valid), .err_log_code(err_log_code),
    .status_summary(status_summary), .event_summary_flag(event_summary_flag));

// *** dv/ser_ctrl_model.sv ***
// Remote controller model driving the decoded command port.
// Assumes a reply registered on the taking edge; callers start at a clock edge.
`timescale 1ns/1ps
module ser_ctrl_model
    import ser_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command out
    output logic cmd_valid,
    output ser_pkg::ser_op_e cmd_op,
    output logic [15:0] cmd_data,
    // Reply in
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = SER_OP_NOP;
        cmd_data = 16'h0000;
    end
    // One command; keep holds the strobe for a back-to-back follower
    task automatic send(input ser_op_e op, input logic [15:0] d, input bit keep);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_data <= d;
        @(posedge clk);
        if (!keep) begin
            // Released data inverted so stale values never look valid
            cmd_valid <= 1'b0;
            cmd_data <= ~d;
        end
    endtask
    // Query and collect the reply in the cycle it stands
    task automatic query(input ser_op_e op, output logic [15:0] v, output logic ok);
        send(op, 16'h0000, 1'b0);
        #1;
        v = rsp_data;
        ok = rsp_valid;
        @(posedge clk);
    endtask
endmodule

// *** dv/ser_top_tb.sv ***
// Self-checking bench for the status reporting block.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module ser_top_tb;
    import ser_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] ev = 6'h00; // opc, host read, new cmd, dev, exec, cmd
    logic [5:0] cnd = 6'h00; // cal, batt, temp, limit, unaligned, ext ref
    logic cmds_pending = 1'b0;
    logic out_pending = 1'b0;
    logic [7:0] err_detail = 8'h00;
    logic cmd_valid, rsp_valid, err_log_valid, event_summary_flag, lv, ok;
    ser_op_e cmd_op;
    logic [15:0] cmd_data, rsp_data, err_log_code, lc, v, r;
    logic [7:0] status_summary;
    int mismatches = 0;
    int checks_done = 0;
    int seed = 17057;
    int base[3] = '{-300, -200, -100};
    ser_op_e cop[6] = '{SER_OP_OPER_COND, SER_OP_QUES_COND, SER_OP_QUES_COND, SER_OP_QUES_COND,
        SER_OP_QUES_COND, SER_OP_FREQ_COND};
    ser_op_e eop[6] = '{SER_OP_OPER_EVT, SER_OP_QUES_EVT, SER_OP_QUES_EVT, SER_OP_QUES_EVT,
        SER_OP_QUES_EVT, SER_OP_FREQ_EVT};
    int bpos[6] = '{0, 2, 4, 9, 10, 8};
    logic [7:0] sm[6] = '{8'h80, 8'h08, 8'h08, 8'h08, 8'h08, 8'h00};
    always #12.5 clk = ~clk;
    ser_top ser_top_inst (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .opc_cmd(ev[0]), .cmds_pending(cmds_pending),
        .host_read_req(ev[1]), .new_cmd(ev[2]), .out_pending(out_pending), .dev_err(ev[3]), .exec_err(ev[4]),
        .cmd_err(ev[5]), .err_detail(err_detail), .err_log_valid(err_log_valid), .err_log_code(err_log_code),
        .calibration_in_progress(cnd[0]), .battery_low(cnd[1]), .temp_abnormal(cnd[2]),
        .limit_violated(cnd[3]), .unaligned_label(cnd[4]), .ext_ref_used(cnd[5]),
        .status_summary(status_summary), .event_summary_flag(event_summary_flag));
    ser_ctrl_model ser_ctrl_model_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    // Expected logged code, detail clamped to 99
    function automatic logic [15:0] code_of(input int b, input logic [7:0] d);
        return 16'(b - ((d > 8'd99) ? 99 : int'(d)));
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic q(input ser_op_e op, input logic [15:0] exp);
        ser_ctrl_model_inst.query(op, v, ok);
        check(ok ? v : 16'hdead, exp);
    endtask
    // One-cycle event pulse; log outputs sampled in the cycle they stand
    task automatic fire(input logic [5:0] e);
        ev <= e;
        @(posedge clk);
        ev <= 6'h00;
        #1;
        lv = err_log_valid;
        lc = err_log_code;
        @(posedge clk);
    endtask
    task automatic wait_chk(input int n, input logic [7:0] exp);
        repeat (n) @(posedge clk);
        #1;
        check({8'h00, status_summary}, {8'h00, exp});
        check({15'h0000, event_summary_flag}, {15'h0000, exp[5]});
        @(posedge clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog sized well beyond the few hundred cycles of the run
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        q(SER_OP_EVT_RD, 16'h0080);
        q(SER_OP_EVT_RD, 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            r = 16'($random(seed)) & 16'hffbd;
            ser_ctrl_model_inst.send(SER_OP_MASK_WR, r, 1'b1);
            q(SER_OP_MASK_RD, {8'h00, r[7:0]});
        end
        ser_ctrl_model_inst.send(SER_OP_MASK_WR, 16'h0000, 1'b0);
        $display("mask test done");
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 3; j++) begin
                err_detail <= (j == 0) ? 8'd0 : (j == 1) ? 8'(($random(seed) & 32'h7f) % 100) : 8'd200;
                @(posedge clk);
                fire(6'h08 << k);
                check({15'h0000, lv}, 16'h0001);
                check(lc, code_of(base[k], err_detail));
                q(SER_OP_EVT_RD, 16'h0008 << k);
            end
        end
        fire(6'h38);
        check(lc, code_of(-100, err_detail));
        q(SER_OP_EVT_RD, 16'h0038);
        $display("error test done");
        for (int i = 0; i < 4; i++) begin
            out_pending <= i[0];
            fire(i[1] ? 6'h04 : 6'h02);
            q(SER_OP_EVT_RD, (i == 0 || i == 3) ? 16'h0004 : 16'h0000);
        end
        out_pending <= 1'b0;
        cmds_pending <= 1'b1;
        fire(6'h01);
        repeat (3) @(posedge clk);
        q(SER_OP_EVT_RD, 16'h0000);
        cmds_pending <= 1'b0;
        repeat (2) @(posedge clk);
        q(SER_OP_EVT_RD, 16'h0001);
        $display("query and completion test done");
        ser_ctrl_model_inst.send(SER_OP_OPER_ENA_WR, 16'hffff, 1'b1);
        ser_ctrl_model_inst.send(SER_OP_QUES_ENA_WR, 16'hffff, 1'b1);
        ser_ctrl_model_inst.send(SER_OP_FREQ_ENA_WR, 16'hffff, 1'b1);
        q(SER_OP_QUES_ENA_RD, 16'h0614);
        q(SER_OP_OPER_ENA_RD, 16'h0001);
        q(SER_OP_FREQ_ENA_RD, 16'h0100);
        for (int i = 0; i < 6; i++) begin
            cnd[i] <= 1'b1;
            wait_chk(6, sm[i]);
            q(cop[i], 16'h0001 << bpos[i]);
            q(eop[i], 16'h0001 << bpos[i]);
            q(eop[i], 16'h0000);
            wait_chk(2, 8'h00);
            cnd[i] <= 1'b0;
            repeat (6) @(posedge clk);
            q(cop[i], 16'h0000);
            q(eop[i], 16'h0000);
        end
        $display("status register test done");
        ser_ctrl_model_inst.send(SER_OP_MASK_WR, 16'h0008, 1'b0);
        fire(6'h08);
        wait_chk(3, 8'h20);
        q(SER_OP_SUM_RD, 16'h0020);
        q(SER_OP_EVT_RD, 16'h0008);
        wait_chk(2, 8'h00);
        cmds_pending <= 1'b1;
        fire(6'h21);
        ser_ctrl_model_inst.send(SER_OP_CLEAR, 16'h0000, 1'b0);
        cmds_pending <= 1'b0;
        repeat (3) @(posedge clk);
        q(SER_OP_EVT_RD, 16'h0000);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        q(SER_OP_EVT_RD, 16'h0080);
        $display("summary and clear test done");
        close_out();
    end
endmodule
